// ==== design/f1x_pkg.sv ====
/*
 * Package for the format 1 no-address executor: opcodes, instruction
 * field positions, register offsets, reset values and phase states.
 * Assumes one 50 MHz clock and 16-bit words throughout.
 */
package f1x_pkg;

   // ----------------------------------------
   // Instruction fields
   // ----------------------------------------
   localparam int FC_LSB = 0;          // Function code bits 00..07
   localparam int S_LSB = 8;           // s digit bits 08..11
   localparam int T_LSB = 12;          // t digit bits 12..15
   localparam int SHIFT_TYPE_BIT = 8;  // Shift type for code 05
   localparam int TEST_ODD_BIT = 9;    // Accumulator odd test
   localparam int TEST_CARRY_BIT = 10; // Adder carry test
   localparam int TEST_BIT_T = 11;     // Accumulator bit t test
   localparam int POLARITY_BIT = 12;   // Channel polarity select

   // ----------------------------------------
   // Function codes
   // ----------------------------------------
   localparam logic [7:0] OP_SET_BIT = 8'h01;
   localparam logic [7:0] OP_CLR_BIT = 8'h02;
   localparam logic [7:0] OP_CMP_BIT = 8'h03;
   localparam logic [7:0] OP_LZC = 8'h04;
   localparam logic [7:0] OP_SHIFT = 8'h05;
   localparam logic [7:0] OP_TO_IDX1 = 8'h06;
   localparam logic [7:0] OP_TO_IDX2 = 8'h07;
   localparam logic [7:0] OP_COND_INT = 8'h08;
   localparam logic [7:0] OP_COND_CHAN = 8'h09;
   localparam logic [7:0] OP_CHAN_SET_T = 8'h0a;
   localparam logic [7:0] OP_CHAN_CLR_T = 8'h0b;
   localparam logic [7:0] OP_CHAN_IN = 8'h0c;
   localparam logic [7:0] OP_CHAN_SET_A = 8'h0d;
   localparam logic [7:0] OP_CHAN_CLR_A = 8'h0e;
   localparam logic [7:0] OP_CHAN_XFER = 8'h0f;
   localparam logic [7:0] OP_ADD_IMM = 8'h10;

   // ----------------------------------------
   // Register map and reset values
   // ----------------------------------------
   localparam logic [3:0] REG_ACC = 4'h0;   // Accumulator
   localparam logic [3:0] REG_IDX1 = 4'h4;  // Index register one
   localparam logic [3:0] REG_IDX2 = 4'h8;  // Index register two
   localparam logic [3:0] REG_FLAGS = 4'hc; // Flags and busy
   localparam int FLAG_COND = 0;            // Condition flag bit
   localparam int FLAG_CARRY = 1;           // Adder carry flag bit
   localparam int FLAG_BUSY = 2;            // Busy, read only
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [3:0] CHAN_ZERO = 4'h0;

   // ----------------------------------------
   // Instruction cycle phases
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, // Waiting for a fetch
      ST_OUT = 2'b01,  // Output timing phase
      ST_END = 2'b10   // Cycle end phase
   } f1x_state_t;

endpackage

// ==== design/f1x_rshift.sv ====
/*
 * Right shift network, end-off or end-around, 0 to W-1 places.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ns
module f1x_rshift #(
   parameter int W = 16
) (
   input wire logic [W-1:0] i_data,   // Word to shift
   input wire logic [3:0] i_amount,   // Places to shift
   input wire logic i_circular,       // One for end-around
   output logic [W-1:0] o_data        // Shifted word
);

   // ----------------------------------------
   // Double-width trick
   // ----------------------------------------
   logic [2*W-1:0] wide; // Upper copy feeds wrap-around bits

   // Upper half is zero for end-off, so bits fall away
   always_comb
   begin
      wide = {(i_circular ? i_data : {W{1'b0}}), i_data} >> i_amount;
      o_data = wide[W-1:0];
   end

endmodule

// ==== design/f1x_exec.sv ====
/*
 * Executor for format 1 no-address instructions, codes 01 to 10.
 * Assumes the coupler holds the channel registers and applies the
 * set and clear strobes to the driven data; inputs are synchronous.
 */
// Our own choices: the placing of the registers and the address-and-strobe port.
// Notes on behaviour
// - Code bits 00-07, s 08-11, t 12-15
// - Each instruction finishes in one fetch cycle
// - Code 01 ORs t decode into accumulator
// - Code 02 clears accumulator bit t
// - Code 03 inverts accumulator bit t
// - Code 04 loads leading zero count
// - Code 05 shifts right by t places
// - Bit 08 picks end-off or end-around
// - Codes 06/07 load index from accumulator+immediate
// - Code 08 ORs selected odd/carry/bit-t tests
// - No test selected clears flag, at end
// - Code 09 loads flag from channel bit
// - Code 0A sets bit t, s>0 clears others
// - Code 0B clears channel zero bit t
// - Code 0C loads accumulator from channel s
// - Bit 12 sets polarity for 0D-0F
// - Code 0D sets channel zero from accumulator
// - Code 0E clears channel zero from accumulator
// - Code 0F copies accumulator to channel s
// - Strobes issue in the output phase
// - Code 10 adds zero-filled immediate
// - Code 10 loads carry at cycle end
// - Sixteen 16-bit input channels, selected by s
`timescale 1ns/1ns
module f1x_exec (
   input wire logic i_clk,                        // 50 MHz clock
   input wire logic i_resetn,                     // Async reset, low
   input wire logic i_instruction_fetch_cycle,    // Offer an instruction
   input wire logic [15:0] i_instr,               // Instruction word
   input wire logic [255:0] i_in_chan,            // Channel n at 16n
   input wire logic [3:0] i_reg_addr,             // Register address
   input wire logic [15:0] i_reg_wdata,           // Register write data
   input wire logic i_reg_wr,                     // Write strobe
   input wire logic i_reg_rd,                     // Read strobe
   output logic [15:0] o_reg_rdata,               // Read data, next cycle
   output logic o_busy,                           // Instruction in flight
   output logic o_output_timing_phase,            // Output phase marker
   output logic o_cycle_end_phase,                // End phase marker
   output logic o_channel_bit_set_strobe,         // Set where data is one
   output logic o_channel_bit_clear_strobe,       // Clear where data is zero
   output logic [3:0] o_out_chan_sel,             // Output channel number
   output logic [15:0] o_out_chan_data,           // Channel driver data
   output logic o_channel_polarity_select,        // One: true data
   output logic [15:0] o_accumulator,             // Accumulator
   output logic o_condition_flag,                 // Condition flag
   output logic o_adder_carry_flag                // Adder carry flag
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   f1x_pkg::f1x_state_t state_reg;  // Cycle phase
   f1x_pkg::f1x_state_t state_next; // Next phase
   logic [15:0] instr_reg;          // Latched instruction
   logic [15:0] acc_reg;            // Accumulator
   logic [15:0] acc_next;           // Accumulator next value
   logic [15:0] idx1_reg;           // Index register one
   logic [15:0] idx2_reg;           // Index register two
   logic cond_reg;                  // Condition flag
   logic carry_reg;                 // Adder carry flag
   logic take;                      // Instruction accepted now
   logic bus_ok;                    // Software may write now

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   logic [7:0] fc;        // Latched function code
   logic [3:0] s_dig;     // Latched s digit
   logic [3:0] t_dig;     // Latched t digit
   logic [7:0] imm;       // Immediate s,t value
   logic [15:0] t_dec;    // One-hot t decode
   logic [7:0] fc_in;     // Incoming function code
   logic [3:0] s_in;      // Incoming s digit
   logic [3:0] t_in;      // Incoming t digit
   logic [15:0] t_dec_in; // Incoming t decode
   logic [15:0] pol_data; // Accumulator after polarity

   assign fc = instr_reg[f1x_pkg::FC_LSB +: 8];
   assign s_dig = instr_reg[f1x_pkg::S_LSB +: 4];
   assign t_dig = instr_reg[f1x_pkg::T_LSB +: 4];
   assign imm = {s_dig, t_dig};
   assign t_dec = 16'h0001 << t_dig;
   assign fc_in = i_instr[f1x_pkg::FC_LSB +: 8];
   assign s_in = i_instr[f1x_pkg::S_LSB +: 4];
   assign t_in = i_instr[f1x_pkg::T_LSB +: 4];
   assign t_dec_in = 16'h0001 << t_in;
   // Polarity one passes true accumulator data
   assign pol_data = i_instr[f1x_pkg::POLARITY_BIT] ? acc_reg : ~acc_reg;

   assign take = i_instruction_fetch_cycle && (state_reg == f1x_pkg::ST_IDLE);
   // Software writes lose to the machine: only when idle and not starting
   assign bus_ok = i_reg_wr && (state_reg == f1x_pkg::ST_IDLE) && !take;

   // ----------------------------------------
   // Datapath networks
   // ----------------------------------------
   logic [15:0] shift_out; // Shift result
   logic [15:0] bit_out;   // Accumulator moved so bit t is at 00
   logic [16:0] add_sum;   // Accumulator plus immediate with carry
   logic [15:0] in_word;   // Selected input channel word
   logic [4:0] lz_count;   // Leading zero count

   // Shift for code 05; bit 08 chooses end-around
   f1x_rshift #(
      .W(16)
   ) u_shift (
      .i_data(acc_reg),
      .i_amount(t_dig),
      .i_circular(instr_reg[f1x_pkg::SHIFT_TYPE_BIT]),
      .o_data(shift_out)
   );

   // Same network picks accumulator bit t for the condition test
   f1x_rshift #(
      .W(16)
   ) u_bit_pick (
      .i_data(acc_reg),
      .i_amount(t_dig),
      .i_circular(1'b0),
      .o_data(bit_out)
   );

   // Upper eight addend bits are zero
   assign add_sum = {1'b0, acc_reg} + {9'h000, imm};
   // Input channel chosen by s from sixteen
   assign in_word = i_in_chan[{s_dig, 4'h0} +: 16];

   // Scale network: zeros above the highest one bit, 16 when empty
   function automatic logic [4:0] lzc(input logic [15:0] w);
      logic [4:0] n;
      logic seen;
      n = 5'h00;
      seen = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         if (w[i])
         begin
            seen = 1'b1;
         end
         else if (!seen)
         begin
            n = n + 5'h01;
         end
      end
      return n;
   endfunction

   assign lz_count = lzc(acc_reg);

   // ----------------------------------------
   // Phase sequencing
   // ----------------------------------------
   // Three phases: take, output, end; no memory cycles ever follow
   always_comb
   begin
      unique case (state_reg)
         f1x_pkg::ST_IDLE: state_next = take ? f1x_pkg::ST_OUT : f1x_pkg::ST_IDLE;
         f1x_pkg::ST_OUT: state_next = f1x_pkg::ST_END;
         f1x_pkg::ST_END: state_next = f1x_pkg::ST_IDLE;
         default: state_next = f1x_pkg::ST_IDLE;
      endcase
   end

   // Phase register and instruction latch
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_reg <= f1x_pkg::ST_IDLE;
         instr_reg <= f1x_pkg::WORD_RESET;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
         begin
            instr_reg <= i_instr;
         end
      end
   end

   // Phase markers, straight from flops
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_busy <= 1'b0;
         o_output_timing_phase <= 1'b0;
         o_cycle_end_phase <= 1'b0;
      end
      else
      begin
         o_busy <= (state_next != f1x_pkg::ST_IDLE);
         o_output_timing_phase <= (state_next == f1x_pkg::ST_OUT);
         o_cycle_end_phase <= (state_next == f1x_pkg::ST_END);
      end
   end

   // ----------------------------------------
   // Accumulator
   // ----------------------------------------
   // Result lands at the end phase
   always_comb
   begin
      acc_next = acc_reg;
      if (state_reg == f1x_pkg::ST_END)
      begin
         case (fc)
            f1x_pkg::OP_SET_BIT: acc_next = acc_reg | t_dec;
            f1x_pkg::OP_CLR_BIT: acc_next = acc_reg & ~t_dec;
            f1x_pkg::OP_CMP_BIT: acc_next = acc_reg ^ t_dec;
            f1x_pkg::OP_LZC: acc_next = {11'h000, lz_count};
            f1x_pkg::OP_SHIFT: acc_next = shift_out;
            f1x_pkg::OP_CHAN_IN: acc_next = in_word;
            f1x_pkg::OP_ADD_IMM: acc_next = add_sum[15:0];
            default: acc_next = acc_reg;                        // Others leave it
         endcase
      end
      else if (bus_ok && (i_reg_addr == f1x_pkg::REG_ACC))
      begin
         acc_next = i_reg_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         acc_reg <= f1x_pkg::WORD_RESET;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   // ----------------------------------------
   // Index registers
   // ----------------------------------------
   // Loaded from accumulator plus immediate; accumulator untouched
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         idx1_reg <= f1x_pkg::WORD_RESET;
         idx2_reg <= f1x_pkg::WORD_RESET;
      end
      else if (state_reg == f1x_pkg::ST_END)
      begin
         if (fc == f1x_pkg::OP_TO_IDX1)
         begin
            idx1_reg <= add_sum[15:0];
         end
         if (fc == f1x_pkg::OP_TO_IDX2)
         begin
            idx2_reg <= add_sum[15:0];
         end
      end
      else if (bus_ok)
      begin
         if (i_reg_addr == f1x_pkg::REG_IDX1)
         begin
            idx1_reg <= i_reg_wdata;
         end
         if (i_reg_addr == f1x_pkg::REG_IDX2)
         begin
            idx2_reg <= i_reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // Condition and carry flags
   // ----------------------------------------
   // Both load from instructions only in the end phase; empty test set gives zero
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cond_reg <= 1'b0;
      end
      else if (state_reg == f1x_pkg::ST_END)
      begin
         if (fc == f1x_pkg::OP_COND_INT)
         begin
            cond_reg <= (instr_reg[f1x_pkg::TEST_ODD_BIT] & acc_reg[0])
               | (instr_reg[f1x_pkg::TEST_CARRY_BIT] & carry_reg)
               | (instr_reg[f1x_pkg::TEST_BIT_T] & bit_out[0]);
         end
         else if (fc == f1x_pkg::OP_COND_CHAN)
         begin
            cond_reg <= in_word[t_dig];
         end
      end
      else if (bus_ok && (i_reg_addr == f1x_pkg::REG_FLAGS))
      begin
         cond_reg <= i_reg_wdata[f1x_pkg::FLAG_COND];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         carry_reg <= 1'b0;
      end
      else if ((state_reg == f1x_pkg::ST_END) && (fc == f1x_pkg::OP_ADD_IMM))
      begin
         carry_reg <= add_sum[16];
      end
      else if (bus_ok && (i_reg_addr == f1x_pkg::REG_FLAGS))
      begin
         carry_reg <= i_reg_wdata[f1x_pkg::FLAG_CARRY];
      end
   end

   // ----------------------------------------
   // Output channel strobes
   // ----------------------------------------
   // Loaded as the instruction is taken, so strobes stand exactly in
   // the output phase. Coupler sets bits where data is one on set and
   // clears bits where data is zero on clear; both together copy.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_channel_bit_set_strobe <= 1'b0;
         o_channel_bit_clear_strobe <= 1'b0;
         o_out_chan_sel <= f1x_pkg::CHAN_ZERO;
         o_out_chan_data <= f1x_pkg::WORD_RESET;
      end
      else
      begin
         o_channel_bit_set_strobe <= 1'b0;
         o_channel_bit_clear_strobe <= 1'b0;
         if (take)
         begin
            case (fc_in)
               f1x_pkg::OP_CHAN_SET_T:
               begin
                  o_channel_bit_set_strobe <= 1'b1;
                  o_channel_bit_clear_strobe <= (s_in != f1x_pkg::CHAN_ZERO);
                  o_out_chan_sel <= s_in;
                  o_out_chan_data <= t_dec_in;
               end
               f1x_pkg::OP_CHAN_CLR_T:
               begin
                  o_channel_bit_clear_strobe <= 1'b1;
                  o_out_chan_sel <= f1x_pkg::CHAN_ZERO;
                  o_out_chan_data <= ~t_dec_in;
               end
               f1x_pkg::OP_CHAN_SET_A:
               begin
                  o_channel_bit_set_strobe <= 1'b1;
                  o_out_chan_sel <= f1x_pkg::CHAN_ZERO;
                  o_out_chan_data <= pol_data;
               end
               f1x_pkg::OP_CHAN_CLR_A:
               begin
                  o_channel_bit_clear_strobe <= 1'b1;
                  o_out_chan_sel <= f1x_pkg::CHAN_ZERO;
                  o_out_chan_data <= pol_data;
               end
               f1x_pkg::OP_CHAN_XFER:
               begin
                  o_channel_bit_set_strobe <= 1'b1;
                  o_channel_bit_clear_strobe <= 1'b1;
                  o_out_chan_sel <= s_in;
                  o_out_chan_data <= pol_data;
               end
               default:
               begin
                  o_out_chan_sel <= o_out_chan_sel;                 // No channel work
               end
            endcase
         end
      end
   end

   // Polarity select follows bit 12 for codes 0D to 0F
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_channel_polarity_select <= 1'b0;
      end
      else if (take && (fc_in >= f1x_pkg::OP_CHAN_SET_A)
               && (fc_in <= f1x_pkg::OP_CHAN_XFER))
      begin
         o_channel_polarity_select <= i_instr[f1x_pkg::POLARITY_BIT];
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // Unmapped addresses read zero; data stands one cycle only
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_reg_rdata <= f1x_pkg::WORD_RESET;
      end
      else if (i_reg_rd)
      begin
         case (i_reg_addr)
            f1x_pkg::REG_ACC: o_reg_rdata <= acc_reg;
            f1x_pkg::REG_IDX1: o_reg_rdata <= idx1_reg;
            f1x_pkg::REG_IDX2: o_reg_rdata <= idx2_reg;
            f1x_pkg::REG_FLAGS: o_reg_rdata <= {13'h0000, o_busy, carry_reg, cond_reg};
            default: o_reg_rdata <= f1x_pkg::WORD_RESET;
         endcase
      end
      else
      begin
         o_reg_rdata <= f1x_pkg::WORD_RESET;
      end
   end

   assign o_accumulator = acc_reg;
   assign o_condition_flag = cond_reg;
   assign o_adder_carry_flag = carry_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_taken;
      take;
   endsequence
   sequence s_phases;
      (state_reg == f1x_pkg::ST_OUT) ##1 (state_reg == f1x_pkg::ST_END)
         ##1 (state_reg == f1x_pkg::ST_IDLE);
   endsequence
   sequence s_end_op(logic [7:0] op);
      (state_reg == f1x_pkg::ST_END) && (fc == op);
   endsequence

   chk_cycle_length: assert property (s_taken |=> s_phases)
      else $error("instruction did not finish in three phases");
   chk_set_bit_a: assert property (s_end_op(f1x_pkg::OP_SET_BIT)
      |=> acc_reg == ($past(acc_reg) | $past(t_dec)))
      else $error("bit set of accumulator wrong");
   chk_clear_bit_a: assert property (s_end_op(f1x_pkg::OP_CLR_BIT)
      |=> acc_reg == ($past(acc_reg) & ~$past(t_dec)))
      else $error("bit clear of accumulator wrong");
   chk_flip_bit_a: assert property (s_end_op(f1x_pkg::OP_CMP_BIT)
      |=> acc_reg == ($past(acc_reg) ^ $past(t_dec)))
      else $error("bit complement of accumulator wrong");
   chk_index_load: assert property (s_end_op(f1x_pkg::OP_TO_IDX1)
      |=> (idx1_reg == $past(acc_reg) + {8'h00, $past(imm)}) && $stable(acc_reg))
      else $error("index one load wrong");
   chk_cond_none: assert property (s_end_op(f1x_pkg::OP_COND_INT)
      ##0 (instr_reg[11:9] == 3'b000) |=> !cond_reg)
      else $error("empty test set left flag set");
   chk_strobe_phase: assert property ((o_channel_bit_set_strobe
      || o_channel_bit_clear_strobe) |-> o_output_timing_phase ##1 o_cycle_end_phase)
      else $error("strobe outside output phase");
   chk_add_carry: assert property (s_end_op(f1x_pkg::OP_ADD_IMM)
      |=> carry_reg == $past(add_sum[16]) && acc_reg == $past(add_sum[15:0]))
      else $error("add result or carry wrong");
   chk_cond_chan: assert property (s_end_op(f1x_pkg::OP_COND_CHAN)
      |=> cond_reg == $past(in_word[t_dig]))
      else $error("channel bit not copied to flag");

endmodule

// ==== verif/f1x_coupler_model.sv ====
/* Coupler model: holds sixteen output channel words and shows
   sixteen fixed input channel words. Assumes one-cycle strobes. */
`timescale 1ns/1ns
module f1x_coupler_model (
   input wire logic i_clk,             // Clock
   input wire logic i_resetn,          // Async reset, low
   input wire logic i_set,             // Set strobe
   input wire logic i_clr,             // Clear strobe
   input wire logic [3:0] i_sel,       // Channel number
   input wire logic [15:0] i_data,     // Driver data
   output logic [255:0] o_in_chan,     // Input channels
   output logic [255:0] o_out_chan     // Output channel words
);
   logic [15:0] word_next; // Selected word after strobes
   // ----------------------------------------
   // Channels
   // ----------------------------------------
   // Input word n is {n, 3c5}, so a wrong select shows
   always_comb
      for (int n = 0; n < 16; n++)
         o_in_chan[16*n +: 16] = {4'(n), 12'h3c5};
   // Set ORs data in, clear ANDs it; both copy it
   assign word_next = (o_out_chan[16*i_sel +: 16] | (i_set ? i_data : 16'h0000))
      & (i_clr ? i_data : 16'hffff);
   always_ff @(posedge i_clk or negedge i_resetn)
      if (!i_resetn)
         o_out_chan <= '0;
      else if (i_set || i_clr)
         o_out_chan[16*i_sel +: 16] <= word_next;
endmodule

// ==== verif/f1x_exec_tb.sv ====
/* Testbench for the format 1 executor with a coupler model.
   Assumes a 50 MHz clock and the register map of the package. */
`timescale 1ns/1ns
module f1x_exec_tb;
   logic i_clk, i_resetn, fetch, wr_s, rd_s, busy, outph, set_s, clr_s, cond, carry;
   logic endph, pol;
   logic [15:0] instr, wdata, rdata, acc, cdata;
   logic [3:0] addr, sel;
   logic [255:0] in_chan, out_chan;
   int bad_count = 0;
   int cmp_count = 0;
   f1x_exec dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_instruction_fetch_cycle(fetch),
      .i_instr(instr), .i_in_chan(in_chan), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .o_busy(busy),
      .o_output_timing_phase(outph), .o_cycle_end_phase(endph), .o_channel_bit_set_strobe(set_s),
      .o_channel_bit_clear_strobe(clr_s), .o_out_chan_sel(sel), .o_out_chan_data(cdata),
      .o_channel_polarity_select(pol), .o_accumulator(acc), .o_condition_flag(cond),
      .o_adder_carry_flag(carry));
   f1x_coupler_model cpl_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_set(set_s),
      .i_clr(clr_s), .i_sel(sel), .i_data(cdata), .o_in_chan(in_chan), .o_out_chan(out_chan));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge i_clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      addr <= a; rd_s <= 1'b1;
      @(posedge i_clk);
      rd_s <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Output phase right after take, end phase next, idle after that
   task automatic ex(input logic [15:0] ins);
      @(posedge i_clk);
      instr <= ins; fetch <= 1'b1;
      @(posedge i_clk);
      fetch <= 1'b0;
      #1 chk({13'h0, outph, endph, busy}, 16'h0005);
      @(posedge i_clk);
      #1 chk({13'h0, outph, endph, busy}, 16'h0003);
      @(posedge i_clk);
      #1 chk({13'h0, outph, endph, busy}, 16'h0000);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // Whole run needs about 135 cycles
   initial
   begin
      repeat (3000) @(posedge i_clk);
      bad_count++;
      finish_test();
   end
   initial
   begin
      i_resetn = 1'b0; fetch = 1'b0; wr_s = 1'b0; rd_s = 1'b0;
      instr = 16'h0000; wdata = 16'h0000; addr = 4'h0;
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(f1x_pkg::REG_ACC, 16'h0000);
      rd(4'h2, 16'h0000);
      wr(f1x_pkg::REG_ACC, 16'h0010);
      ex(16'h3001); chk(acc, 16'h0018);
      ex(16'h4002); chk(acc, 16'h0008);
      ex(16'hf003); chk(acc, 16'h8008);
      ex(16'h0004); chk(acc, 16'h0000);
      ex(16'h0004); chk(acc, 16'h0010);
      wr(f1x_pkg::REG_ACC, 16'h8001);
      ex(16'h4005); chk(acc, 16'h0800);
      wr(f1x_pkg::REG_ACC, 16'h8001);
      ex(16'h4105); chk(acc, 16'h1800);
      wr(f1x_pkg::REG_ACC, 16'h0101);
      ex(16'h5a06); rd(f1x_pkg::REG_IDX1, 16'h01a6);
      ex(16'hff07); rd(f1x_pkg::REG_IDX2, 16'h0200);
      ex(16'h0208); chk({15'h0, cond}, 16'h0001);
      ex(16'h0008); chk({15'h0, cond}, 16'h0000);
      ex(16'h8808); chk({15'h0, cond}, 16'h0001);
      wr(f1x_pkg::REG_ACC, 16'hfff1);
      ex(16'hf010); chk(acc, 16'h0000); chk({15'h0, carry}, 16'h0001);
      ex(16'h0408); rd(f1x_pkg::REG_FLAGS, 16'h0003);
      wr(f1x_pkg::REG_FLAGS, 16'h0002);
      rd(f1x_pkg::REG_FLAGS, 16'h0002);
      ex(16'h070c); chk(acc, 16'h73c5);
      ex(16'hf709); chk({15'h0, cond}, 16'h0000);
      ex(16'he709); chk({15'h0, cond}, 16'h0001);
      ex(16'h120f); chk(out_chan[32 +: 16], 16'h73c5); chk({15'h0, pol}, 16'h0001);
      ex(16'h520a); chk(out_chan[32 +: 16], 16'h0020);
      ex(16'h030f); chk(out_chan[48 +: 16], 16'h8c3a); chk({15'h0, pol}, 16'h0000);
      ex(16'h500a); ex(16'h300a); chk(out_chan[15:0], 16'h0028);
      ex(16'h500b); chk(out_chan[15:0], 16'h0008);
      ex(16'h100d); chk(out_chan[15:0], 16'h73cd);
      ex(16'h000e); chk(out_chan[15:0], 16'h0008);
      ex(16'h000d); chk(out_chan[15:0], 16'h8c3a);
      ex(16'h100e); chk(out_chan[15:0], 16'h0000);
      finish_test();
   end
endmodule
